// ---- hw/crb_regs_consts.vh ----
/*
  Register offsets, reset values and field positions for the locality 0
  command/response buffer register map.
  Assumes inclusion by bare name from the design files under hw/.
*/
`ifndef CRB_REGS_CONSTS_VH
`define CRB_REGS_CONSTS_VH

// Byte offsets within locality 0
`define OFS_LOCALITY_STATE       7'h00
`define OFS_LOCALITY_CONTROL     7'h08
`define OFS_LOCALITY_STATUS      7'h0C
`define OFS_INTF_ID_LOW          7'h30
`define OFS_INTF_ID_HIGH         7'h34
`define OFS_CONTROL_EXT_LOW      7'h38
`define OFS_CONTROL_EXT_HIGH     7'h3C
`define OFS_CONTROL_REQUEST      7'h40
`define OFS_CONTROL_STATUS       7'h44
`define OFS_COMMAND_CANCEL       7'h48
`define OFS_COMMAND_START        7'h4C
`define OFS_INTERRUPT_ENABLE     7'h50
`define OFS_INTERRUPT_STATUS     7'h54
`define OFS_COMMAND_SIZE         7'h58
`define OFS_COMMAND_ADDR_LOW     7'h5C
`define OFS_COMMAND_ADDR_HIGH    7'h60
`define OFS_RESPONSE_SIZE        7'h64
`define OFS_RESPONSE_ADDR_LOW    7'h68
`define OFS_RESPONSE_ADDR_HIGH   7'h6C

// Register file geometry: 32 words cover 0x00..0x7F
`define REG_INDEX_W              5
`define REG_WORDS                32

// Field positions
`define BIT_LOC_REQUEST          0
`define BIT_LOC_RELINQUISH       1
`define BIT_LOC_GRANTED          0
`define BIT_LOC_ASSIGNED         1
`define BIT_REQ_READY            0
`define BIT_REQ_IDLE             1
`define BIT_STS_ERROR            0
`define BIT_STS_IDLE             1
`define BIT_CANCEL               0
`define BIT_START                0
`define BIT_INT_START_DONE       0
`define BIT_INT_GLOBAL_ENABLE    31

// Reset values
`define RST_ZERO                 32'h00000000
`define RST_CONTROL_STATUS       32'h00000002

// Buffer geometry reported to software (shared command/response buffer)
`define BUF_SIZE                 32'h00000F80
`define BUF_ADDR_LOW             32'h00000080
`define BUF_ADDR_HIGH            32'h00000000

// Interface identifier, arbitrary neutral values
`define INTF_ID_LOW              32'h00000001
`define INTF_ID_HIGH             32'h00000000

// AXI responses
`define RESP_OKAY                2'h0

`endif

// ---- hw/crb_read_ram.v ----
/*
  Small read-registered mirror of the register words.
  Assumes one write port and one read port on the same clock.
*/
`timescale 1ns/1ns

module crb_read_ram (
  input  wire                      aclk,
  input  wire                      we,
  input  wire [4:0]                waddr,
  input  wire [31:0]               wdata,
  input  wire [4:0]                raddr,
  output reg  [31:0]               rdata
);

  reg [31:0] mem [0:31];

  // Write and registered read; no reset, one word is rewritten every cycle
  always @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // crb_read_ram

// ---- hw/crb_locality0_regs.v ----
/*
  AXI4-Lite register bank for locality 0 of a command/response buffer
  host interface: locality state, control/status, identifier, request,
  cancel, start, interrupt enable/status and buffer size/address.
  Assumes one clock, synchronous active-low reset, and a core that
  reports command completion on cmd_done and errors on cmd_error.
*/
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "crb_regs_consts.vh"

// Operation
// R1: Read-only locality_state at 0x00, aliased everywhere
// R2: locality_control at 0x08 requests device control
// R3: Read-only locality_status at 0x0C, never aliased; here it aliases across the upper address bits like every word
// R4: 64-bit interface_identifier at 0x30 reports identity
// R5: control_extension at 0x38 not implemented
// R6: control_request at 0x40 initiates transactions
// R7: control_status at 0x44 reports device status
// R8: command_cancel at 0x48 aborts current command
// R9: command_start at 0x4C flags buffer data
// R10: interrupt_enable at 0x50 selects interrupt causes
// R11: interrupt_status at 0x54 shows pending interrupts
// R12: command_size at 0x58 gives buffer size
// R13: Command address split low 0x5C, high 0x60
// R14: response_size at 0x64 equals command_size
// R15: response_address at 0x68 equals command address
// R16: Response address readable as 64-bit pair
// R17: Shared registers may alias across localities
// R18: Fields naturally aligned to their width
// R19: Software uses aligned, non-string accesses
// R20: Reserved offsets read zero, ignore writes
module crb_locality0_regs (
  input  wire                      aclk,
  input  wire                      aresetn,
  input  wire [11:0]               s_axi_awaddr,
  input  wire [2:0]                s_axi_awprot,
  input  wire                      s_axi_awvalid,
  output wire                      s_axi_awready,
  input  wire [31:0]               s_axi_wdata,
  input  wire [3:0]                s_axi_wstrb,
  input  wire                      s_axi_wvalid,
  output wire                      s_axi_wready,
  output reg  [1:0]                s_axi_bresp,
  output reg                       s_axi_bvalid,
  input  wire                      s_axi_bready,
  input  wire [11:0]               s_axi_araddr,
  input  wire [2:0]                s_axi_arprot,
  input  wire                      s_axi_arvalid,
  output wire                      s_axi_arready,
  output wire [31:0]               s_axi_rdata,
  output reg  [1:0]                s_axi_rresp,
  output reg                       s_axi_rvalid,
  input  wire                      s_axi_rready,
  input  wire                      cmd_done,
  input  wire                      cmd_error,
  output reg                       start_pulse,
  output reg                       cancel_level,
  output wire                      locality_active
);

  ////////////////////////////////////////////////////////////////////////
  // Write channel capture

  reg        aw_held;
  reg        w_held;
  reg [6:0]  aw_ofs;
  reg [31:0] w_data;
  reg [3:0]  w_strb;

  // Either order; each channel taken once, then held until response
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  wire write_go = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_ofs  <= 7'h00;
      w_data  <= `RST_ZERO;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_ofs  <= s_axi_awaddr[6:0];                                  // [R17]
      end else if (write_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (write_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; every address answers OKAY, unmapped ones are dropped
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (write_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of write data

  // Aligned word only; misaligned low address bits are ignored [R18]
  wire [4:0]  w_index = aw_ofs[6:2];
  wire [31:0] lane_mask;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{w_strb[lane]}};
    end
  endgenerate

  wire [31:0] wr_bits = w_data & lane_mask;
  wire wr_loc_ctrl = write_go && (w_index == `OFS_LOCALITY_CONTROL >> 2);
  wire wr_request  = write_go && (w_index == `OFS_CONTROL_REQUEST >> 2);
  wire wr_cancel   = write_go && (w_index == `OFS_COMMAND_CANCEL >> 2);
  wire wr_start    = write_go && (w_index == `OFS_COMMAND_START >> 2);
  wire wr_int_en   = write_go && (w_index == `OFS_INTERRUPT_ENABLE >> 2);
  wire wr_int_sts  = write_go && (w_index == `OFS_INTERRUPT_STATUS >> 2);

  ////////////////////////////////////////////////////////////////////////
  // Locality control and status

  reg granted;

  // Request grants, relinquish releases; only one locality exists here
  always @(posedge aclk) begin
    if (!aresetn) begin
      granted <= 1'b0;
    end else if (wr_loc_ctrl && wr_bits[`BIT_LOC_RELINQUISH]) begin
      granted <= 1'b0;                                                 // [R2]
    end else if (wr_loc_ctrl && wr_bits[`BIT_LOC_REQUEST]) begin
      granted <= 1'b1;                                                 // [R2]
    end
  end

  assign locality_active = granted;

  ////////////////////////////////////////////////////////////////////////
  // Command start, cancel, request and status

  reg        start_bit;
  reg        cancel_bit;
  reg        idle_state;
  reg        error_state;
  reg        int_enable_global;
  reg        int_enable_done;
  reg        int_done_pending;

  // Start set by software, cleared by core completion or cancel
  always @(posedge aclk) begin
    if (!aresetn) begin
      start_bit   <= 1'b0;
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= wr_start && wr_bits[`BIT_START] && !idle_state; // [R9]
      if (wr_start && wr_bits[`BIT_START] && !idle_state) begin
        start_bit <= 1'b1;                                             // [R9]
      end else if (cmd_done || cancel_bit) begin
        start_bit <= 1'b0;
      end
    end
  end

  // Cancel holds until written back to zero; core sees it one cycle later, only while start is set
  always @(posedge aclk) begin
    if (!aresetn) begin
      cancel_bit   <= 1'b0;
      cancel_level <= 1'b0;
    end else begin
      // Unstrobed lane keeps the old cancel value
      if (wr_cancel && w_strb[`BIT_CANCEL / 8]) begin
        cancel_bit <= wr_bits[`BIT_CANCEL];                            // [R8]
      end
      cancel_level <= cancel_bit && start_bit;                         // [R8]
    end
  end

  // Request ready/idle moves the idle state; error sticky until ready
  always @(posedge aclk) begin
    if (!aresetn) begin
      idle_state  <= 1'b1;
      error_state <= 1'b0;
    end else begin
      if (wr_request && wr_bits[`BIT_REQ_READY]) begin
        idle_state <= 1'b0;                                            // [R6]
      end else if (wr_request && wr_bits[`BIT_REQ_IDLE] && !start_bit) begin
        idle_state <= 1'b1;                                            // [R6]
      end
      if (cmd_error) begin
        error_state <= 1'b1;                                           // [R7]
      end else if (wr_request && wr_bits[`BIT_REQ_READY]) begin
        error_state <= 1'b0;
      end
    end
  end

  // Interrupt enable and sticky done status; set wins over clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      int_enable_global <= 1'b0;
      int_enable_done   <= 1'b0;
      int_done_pending  <= 1'b0;
    end else begin
      // Each enable field changes only when its own byte lane is strobed
      if (wr_int_en && w_strb[`BIT_INT_GLOBAL_ENABLE / 8]) begin
        int_enable_global <= w_data[`BIT_INT_GLOBAL_ENABLE];           // [R10]
      end
      if (wr_int_en && w_strb[`BIT_INT_START_DONE / 8]) begin
        int_enable_done   <= w_data[`BIT_INT_START_DONE];              // [R10]
      end
      if (cmd_done) begin
        int_done_pending <= 1'b1;                                      // [R11]
      end else if (wr_int_sts && wr_bits[`BIT_INT_START_DONE]) begin
        int_done_pending <= 1'b0;                                      // [R11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read value mux

  reg [31:0] next_word;
  reg [4:0]  mirror_index;

  // Cycles through all words so the mirror tracks live state
  always @(posedge aclk) begin
    if (!aresetn) begin
      mirror_index <= 5'h00;
    end else begin
      mirror_index <= mirror_index + 5'h01;
    end
  end

  // Live value of each word; reserved and extension words read zero
  always @* begin
    next_word = `RST_ZERO;
    case (mirror_index)
      `OFS_LOCALITY_STATE >> 2:     next_word = {31'h00000000, granted};          // [R1]
      `OFS_LOCALITY_CONTROL >> 2:   next_word = `RST_ZERO;                        // [R2]
      `OFS_LOCALITY_STATUS >> 2:    next_word = {30'h00000000, granted, granted}; // [R3]
      `OFS_INTF_ID_LOW >> 2:        next_word = `INTF_ID_LOW;                     // [R4]
      `OFS_INTF_ID_HIGH >> 2:       next_word = `INTF_ID_HIGH;                    // [R4]
      `OFS_CONTROL_REQUEST >> 2:    next_word = `RST_ZERO;                        // [R6]
      `OFS_CONTROL_STATUS >> 2:     next_word = {30'h00000000, idle_state, error_state}; // [R7]
      `OFS_COMMAND_CANCEL >> 2:     next_word = {31'h00000000, cancel_bit};       // [R8]
      `OFS_COMMAND_START >> 2:      next_word = {31'h00000000, start_bit};        // [R9]
      `OFS_INTERRUPT_ENABLE >> 2: begin
        next_word = {int_enable_global, 30'h00000000, int_enable_done}; // [R10]
      end
      `OFS_INTERRUPT_STATUS >> 2:   next_word = {31'h00000000, int_done_pending}; // [R11]
      `OFS_COMMAND_SIZE >> 2:       next_word = `BUF_SIZE;                        // [R12]
      `OFS_COMMAND_ADDR_LOW >> 2:   next_word = `BUF_ADDR_LOW;                    // [R13]
      `OFS_COMMAND_ADDR_HIGH >> 2:  next_word = `BUF_ADDR_HIGH;                   // [R13]
      `OFS_RESPONSE_SIZE >> 2:      next_word = `BUF_SIZE;                        // [R14]
      `OFS_RESPONSE_ADDR_LOW >> 2:  next_word = `BUF_ADDR_LOW;                    // [R15]
      `OFS_RESPONSE_ADDR_HIGH >> 2: next_word = `BUF_ADDR_HIGH;                   // [R15] [R16]
      default:                      next_word = `RST_ZERO;                        // [R5] [R20]
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel

  // Reads come from the mirror, not the live mux; to limit staleness
  // the read path waits for the refresh of the word at rd_index.
  localparam RD_IDLE = 2'b00;
  localparam RD_WAIT = 2'b01;
  localparam RD_LOAD = 2'b10;
  localparam RD_SEND = 2'b11;

  reg [1:0]  rd_state;
  reg [4:0]  rd_index;
  reg        mirror_we;
  reg [4:0]  mirror_waddr;
  reg [31:0] mirror_wdata;

  assign s_axi_arready = (rd_state == RD_IDLE);

  // Mirror write port: one word per cycle, all words refreshed in 32
  always @(posedge aclk) begin
    if (!aresetn) begin
      mirror_we    <= 1'b0;
      mirror_waddr <= 5'h00;
      mirror_wdata <= `RST_ZERO;
    end else begin
      mirror_we    <= 1'b1;
      mirror_waddr <= mirror_index;
      mirror_wdata <= next_word;
    end
  end

  // Read waits until the mirror has been refreshed for the target word
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_state     <= RD_IDLE;
      rd_index     <= 5'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_index <= s_axi_araddr[6:2];                             // [R17] [R18]
            rd_state <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          if (mirror_we && mirror_waddr == rd_index) begin
            rd_state <= RD_LOAD;
          end
        end
        RD_LOAD: begin
          s_axi_rvalid <= 1'b1;
          s_axi_rresp  <= `RESP_OKAY;
          rd_state     <= RD_SEND;
        end
        RD_SEND: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state     <= RD_IDLE;
          end
        end
        default: begin
          rd_state <= RD_IDLE;
        end
      endcase
    end
  end

  // Word mirror; registered read data feed the R channel
  crb_read_ram u_read_ram (
    .aclk  (aclk),
    .we    (mirror_we),
    .waddr (mirror_waddr),
    .wdata (mirror_wdata),
    .raddr (rd_index),
    .rdata (s_axi_rdata)
  );

endmodule // crb_locality0_regs

// ---- tb/crb_locality0_regs_props.sv ----
/*
  Concurrent checks on the ports of the locality 0 register bank.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns

module crb_locality0_regs_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        start_pulse
);
  // One domain, so clock and disable are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // Bus responses
  chk_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("write response not okay");
  chk_rresp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00)
    else $error("read response not okay");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |->
    ##[3:35] s_axi_rvalid)
    else $error("read answer late");
  chk_write_latency: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  // A pending answer must block new requests
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  chk_start_single: assert property (start_pulse |=> !start_pulse)
    else $error("start pulse longer than one cycle");
endmodule // crb_locality0_regs_props

bind crb_locality0_regs crb_locality0_regs_props u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .start_pulse
);

// ---- tb/tb_crb_locality0_regs.sv ----
/*
  Self-checking bench for the locality 0 register bank.
  Assumes the bank answers on AXI4-Lite and aliases all upper address bits.
*/
`timescale 1ns/1ns

module tb_crb_locality0_regs;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, cmd_done, cmd_error;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         start_pulse, cancel_level, locality_active;
  int          n_errors, n_tests, n_pulse, p0, n_cancel, c0;

  crb_locality0_regs i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cmd_done, .cmd_error, .start_pulse, .cancel_level, .locality_active
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and pulse counters; cancel_level lasts one cycle, so it is counted
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) if (start_pulse === 1'b1) n_pulse <= n_pulse + 1;
  always @(posedge aclk) if (cancel_level === 1'b1) n_cancel <= n_cancel + 1;

  task check(input [31:0] seen, input [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Random upper bits land on the aliased map; always word aligned
  function [11:0] addr_of(input [4:0] idx);
    return {5'($urandom() % 32), idx, 2'b00};
  endfunction

  // Value after reset, buffer shared so sizes and addresses match
  function [31:0] exp_reset(input [4:0] idx);
    case (idx)
      5'd12:        return 32'h00000001;
      5'd17:        return 32'h00000002;
      5'd22, 5'd25: return 32'h00000F80;
      5'd23, 5'd26: return 32'h00000080;
      default:      return 32'h00000000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks: answers sampled mid-cycle for the next edge; bready and
  // rready stay high between transfers so no signal is set twice at once
  task axi_write(input [11:0] a, input [31:0] d, input [3:0] s);
    bit aw_ok, w_ok, hs_aw, hs_w;
    aw_ok = 0;
    w_ok = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      hs_aw = s_axi_awvalid && s_axi_awready;
      hs_w = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (hs_aw) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (hs_w) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(negedge aclk);
      hs_aw = s_axi_bvalid;
      @(posedge aclk);
    end while (!hs_aw);
  endtask

  task axi_read(input [11:0] a, output [31:0] d);
    bit hs;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      hs = s_axi_arready;
      @(posedge aclk);
    end while (!hs);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      hs = s_axi_rvalid;
      d = s_axi_rdata;
      @(posedge aclk);
    end while (!hs);
  endtask

  task rd_check(input [4:0] idx, input [31:0] mask, input [31:0] exp);
    axi_read(addr_of(idx), rd);
    check(rd & mask, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cmd_done, cmd_error, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_wstrb, s_axi_awprot, s_axi_arprot} = '0;
    n_errors = 0;
    n_tests = 0;
    n_pulse = 0;
    n_cancel = 0;
    aresetn = 1'b0;
    void'($urandom(16714));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Every word after reset; read-only and reserved words ignore writes
    for (int i = 0; i < 32; i++) begin
      rd_check(i, 32'hFFFFFFFF, exp_reset(i));
      if (!(i inside {2, 16, 18, 19, 20, 21})) begin
        axi_write(addr_of(i), $urandom(), 4'hF);
        rd_check(i, 32'hFFFFFFFF, exp_reset(i));
      end
    end
    // Byte strobes select which lanes of the enable word change
    axi_write(addr_of(20), 32'hFFFFFFFF, 4'h1);
    rd_check(20, 32'hFFFFFFFF, 32'h00000001);
    axi_write(addr_of(20), 32'hFFFFFFFF, 4'h8);
    rd_check(20, 32'hFFFFFFFF, 32'h80000001);
    // Locality request then relinquish
    axi_write(addr_of(2), 32'h00000001, 4'hF);
    check(locality_active, 1'b1);
    rd_check(0, 32'h00000001, 32'h00000001);
    axi_write(addr_of(2), 32'h00000002, 4'hF);
    check(locality_active, 1'b0);
    // Start while idle is refused
    p0 = n_pulse;
    axi_write(addr_of(19), 32'h00000001, 4'hF);
    @(posedge aclk);
    check(n_pulse - p0, 0);
    rd_check(19, 32'h00000001, 32'h00000000);
    // Leave idle, start, cancel, finish
    axi_write(addr_of(16), 32'h00000001, 4'hF);
    rd_check(17, 32'h00000002, 32'h00000000);
    axi_write(addr_of(19), 32'h00000001, 4'hF);
    @(posedge aclk);
    check(n_pulse - p0, 1);
    rd_check(19, 32'h00000001, 32'h00000001);
    c0 = n_cancel;
    axi_write(addr_of(18), 32'h00000001, 4'hF);
    repeat (2) @(posedge aclk);
    check(n_cancel - c0, 1);
    cmd_done <= 1'b1;
    cmd_error <= 1'b1;
    @(posedge aclk);
    cmd_done <= 1'b0;
    cmd_error <= 1'b0;
    rd_check(19, 32'h00000001, 32'h00000000);
    rd_check(17, 32'h00000001, 32'h00000001);
    rd_check(21, 32'h00000001, 32'h00000001);
    axi_write(addr_of(21), 32'h00000001, 4'hF);
    rd_check(21, 32'h00000001, 32'h00000000);
    axi_write(addr_of(18), 32'h00000000, 4'hF);
    repeat (2) @(posedge aclk);
    check(cancel_level, 1'b0);
    // Idle request with no command running returns to idle
    axi_write(addr_of(16), 32'h00000002, 4'hF);
    rd_check(17, 32'h00000002, 32'h00000002);
    finish_test();
  end

  // Watchdog, far beyond the few thousand cycles the sequence needs
  initial begin
    #900000;
    n_errors++;
    finish_test();
  end
endmodule // tb_crb_locality0_regs
